// File: cpu_status_flags_low_tb.sv
// Self-checking bench for the status flags low byte over AHB-Lite.
// Assumes csf_pkg, the design modules and csf_core_model are compiled first.
module cpu_status_flags_low_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import csf_pkg::*;
    logic ref_clk, sys_rst, hsel, hwrite, hreadyout, hresp, uib, dph_rd, rp;
    logic rpt, fwe, lwe;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, lv, lvc;
    logic [31:0] hwdata, hrdata;
    logic [31:0] expq[$];
    logic [7:0] status_out;
    logic [3:0] cpl, fl, fm, m;
    logic [15:0] oa, ob, a, b;
    csf_op_t cop, o;
    int err_count, n_tests;

    // Clock of 50 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    csf_core_model u_csf_core_model (.ref_clk(ref_clk), .rpt(rpt), .flag_we(fwe), .mask(fm),
        .op(cop), .op_a(oa), .op_b(ob), .lvl_we(lwe), .lvl(lvc));

    csf_status_flags u_csf_status_flags (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .repeat_loop_active(rpt), .core_flag_we(fwe),
        .core_flag_mask(fm), .core_op(cop), .core_op_a(oa), .core_op_b(ob),
        .core_level_we(lwe), .core_level(lvc), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .status_out(status_out), .cpu_priority_level(cpl),
        .user_irq_block(uib));

    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Waits for hready under a bound; a hang counts as a mismatch.
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_count++;
            print_verdict();
        end
    endtask

    // One single word transfer; reads leave their expected data in the queue.
    task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d, e);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        if (!w) expq.push_back(e);
        wait_rdy();
    endtask

    // Takes the oldest expectation whenever read data comes back.
    always @(posedge ref_clk) begin
        if (dph_rd && hreadyout === 1'b1) chk("hrdata", hrdata, expq.pop_front());
        dph_rd <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    // Expected flag nibble {neg, overflow, zero, carry} of an add, subtract or logic AND.
    function automatic logic [3:0] calc(input csf_op_t op, input logic [15:0] x, y);
        logic [16:0] s;
        logic v;
        s = (op == CSF_OP_ADD) ? {1'b0, x} + {1'b0, y} :
            (op == CSF_OP_SUB) ? {1'b0, x} - {1'b0, y} : {1'b0, x & y};
        v = (op == CSF_OP_ADD) ? (x[15] == y[15]) : (op == CSF_OP_SUB) && (x[15] != y[15]);
        return {s[15], v && (s[15] != x[15]), s[15:0] == 16'h0,
                (op == CSF_OP_SUB) ? ~s[16] : s[16]};
    endfunction

    function automatic logic [31:0] st();
        return {24'h0, lv, rp, fl};
    endfunction

    // Main sequence.
    initial begin
        void'($urandom(32'h64490eb8));
        {sys_rst, hsel, hwrite, rp} = 4'h8;
        {haddr, htrans, hwdata} = 46'h0;
        hsize = 3'h2;
        {err_count, n_tests} = 0;
        {fl, lv} = 7'h0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1 chk("reset", {hreadyout, hresp, uib, cpl, status_out}, 32'h00004000);
        bus(0, 12'h000, 32'h0, st());
        for (int i = 0; i < 8; i++) begin
            lv = i[2:0];
            fl = 4'($urandom);
            bus(1, 12'h000, st(), 32'h0);
            bus(0, 12'h000, 32'h0, st());
            #1 chk("prio", cpl, {1'b0, lv});
            chk("block", uib, lv == 3'h7);
        end
        lv = 3'h3;
        bus(1, 12'h000, st(), 32'h0);
        bus(1, 12'h004, 32'h1, 32'h0);
        bus(0, 12'h004, 32'h0, 32'h1);
        #1 chk("msb", {uib, cpl}, 5'h1b);
        bus(1, 12'h004, 32'h2, 32'h0);
        bus(1, 12'h000, {24'h0, 3'h6, 1'b0, fl}, 32'h0);
        bus(0, 12'h000, 32'h0, st());
        bus(1, 12'h004, 32'h0, 32'h0);
        u_csf_core_model.level(3'h5);
        lv = 3'h5;
        bus(1, 12'h010, 32'hffff_ffff, 32'h0);
        bus(0, 12'h010, 32'h0, 32'h0);
        for (int i = 0; i < 2; i++) begin
            rp = ~rp;
            u_csf_core_model.set_rpt(rp);
            bus(0, 12'h000, 32'h0, st());
            #1 chk("status_out", status_out, st());
        end
        for (int i = 0; i < 40; i++) begin
            a = (i < 4) ? 16'(64'h7fff_ffff_0000_0005 >> (48 - 16 * i)) : 16'($urandom);
            b = (i < 4) ? ((i == 3) ? 16'h0005 : 16'h0001) : 16'($urandom);
            o = (i < 2) ? CSF_OP_ADD : (i < 4) ? CSF_OP_SUB : csf_op_t'($urandom_range(2, 0));
            m = (i < 4) ? 4'hf : 4'($urandom);
            // A logic operation updates only the negative and zero flags.
            if (o == CSF_OP_LOGIC) m = m & 4'ha;
            u_csf_core_model.alu(o, a, b, m);
            fl = (m & calc(o, a, b)) | (~m & fl);
            bus(0, 12'h000, 32'h0, st());
            #1 chk("status_out", status_out, st());
        end
        // A second reset in mid-run must bring every output and the status and control registers back.
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        {fl, lv} = 7'h0;
        @(posedge ref_clk);
        #1 chk("rerun", {hreadyout, hresp, uib, cpl, status_out}, 32'h00004000);
        chk("rerun_rd", hrdata, 32'h0);
        bus(0, 12'h004, 32'h0, 32'h0);
        bus(0, 12'h000, 32'h0, st());
        print_verdict();
    end
endmodule

// File: csf_alu_flags.sv
// Combinational flag generator for one 16-bit ALU operation.
// Assumes operands are stable for the cycle in which the core updates flags.
module csf_alu_flags #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] op_a,
    input  wire logic [WIDTH-1:0] op_b,
    input  wire logic [1:0]       op_kind,
    output logic [WIDTH-1:0]      result,
    output logic                  neg,
    output logic                  ovf,
    output logic                  nonzero,
    output logic                  carry
);
    import csf_pkg::*;
    logic [WIDTH:0] sum_ext;
    wire  is_sub = (op_kind == 2'(CSF_OP_SUB));
    wire  is_log = (op_kind == 2'(CSF_OP_LOGIC));
    wire  [WIDTH-1:0] b_eff = is_sub ? ~op_b : op_b;

    // Sum with carry in set for subtraction, so carry out acts as not-borrow.
    assign sum_ext = {1'b0, op_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, is_sub};
    assign result  = is_log ? (op_a & op_b) : sum_ext[WIDTH-1:0];
    assign neg     = result[WIDTH-1];
    assign nonzero = |result;
    assign carry   = sum_ext[WIDTH];
    // Overflow when both effective operands share a sign that the result lacks.
    assign ovf     = (op_a[WIDTH-1] == b_eff[WIDTH-1]) && (result[WIDTH-1] != op_a[WIDTH-1]);
endmodule

// File: csf_core_model.sv
// Core-side model: repeat state, flag update strobes and level loads.
// Assumes callers enter its tasks just after a rising edge of ref_clk.
module csf_core_model (
    input  wire logic        ref_clk,
    output logic             rpt,
    output logic             flag_we,
    output logic [3:0]       mask,
    output csf_pkg::csf_op_t op,
    output logic [15:0]      op_a,
    output logic [15:0]      op_b,
    output logic             lvl_we,
    output logic [2:0]       lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    import csf_pkg::*;

    // Idle values; operands are scrambled between strobes so stale data never passes.
    initial begin
        {rpt, flag_we, lvl_we} = 3'h0;
        mask = 4'h0;
        op = CSF_OP_NONE;
        {op_a, op_b} = 32'h0;
        lvl = 3'h0;
    end

    // One flag update strobe, then operands are inverted and a cycle settles.
    task automatic alu(input csf_op_t o, input logic [15:0] a, b, input logic [3:0] m);
        flag_we <= 1'b1;
        op <= o;
        op_a <= a;
        op_b <= b;
        mask <= m;
        @(posedge ref_clk);
        flag_we <= 1'b0;
        op_a <= ~a;
        op_b <= ~b;
        @(posedge ref_clk);
    endtask

    // Loads a priority level from the core side.
    task automatic level(input logic [2:0] v);
        lvl_we <= 1'b1;
        lvl <= v;
        @(posedge ref_clk);
        lvl_we <= 1'b0;
        lvl <= ~v;
        @(posedge ref_clk);
    endtask

    // Starts or ends a single-instruction repeat loop.
    task automatic set_rpt(input logic v);
        rpt <= v;
        @(posedge ref_clk);
    endtask
endmodule

// File: csf_defines.svh
// Constants for the status flags low byte: offsets, bit positions, reset values.
// Assumes inclusion by bare name from the status flags module.
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define CSF_OFS_STATUS   12'h000
`define CSF_OFS_CTRL     12'h004
`define CSF_OFS_ALU_OP   12'h008
`define CSF_OFS_ALU_RES  12'h00c
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define CSF_BIT_LVL_HI   7
`define CSF_BIT_LVL_LO   5
`define CSF_BIT_RPT      4
`define CSF_BIT_NEG      3
`define CSF_BIT_OVF      2
`define CSF_BIT_ZERO     1
`define CSF_BIT_CARRY    0
`define CSF_BIT_MSB_PL   0
`define CSF_BIT_NSTD     1
// -----------------------------------------------------------------
// Reset values and maximum level
// -----------------------------------------------------------------
`define CSF_RST_STATUS   8'h00
`define CSF_RST_LEVEL    3'h0
`define CSF_LEVEL_MAX    3'h7
`endif

// File: csf_pkg.sv
// Types shared by the status flags block.
// Assumes csf_defines.svh is on the include path.
package csf_pkg;
    typedef enum logic [1:0] {
        CSF_OP_ADD,
        CSF_OP_SUB,
        CSF_OP_LOGIC,
        CSF_OP_NONE
    } csf_op_t;
    typedef enum logic [1:0] {
        CSF_BUS_IDLE,
        CSF_BUS_WRITE,
        CSF_BUS_READ
    } csf_bus_st_t;
endpackage

// File: csf_status_flags.sv
// Low byte of the core status register with an AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, synchronous inputs.
// What this block does
// - Bits 7 to 5 hold the current priority level 0 to 7 in plain binary.
// - A level field of 111 blocks all user interrupts.
// - A fourth level bit forms levels 8 to 15 and, when one, blocks user interrupts.
// - While nesting disable is one, software writes to bits 7 to 5 are ignored; the fourth level bit stays writable.
// - Bit 4 is one from the cycle after a single-instruction repeat loop starts until the cycle after it ends.
// - Bit 3 follows the sign of the result of an updating ALU operation.
// - Bit 2 is set on signed overflow and cleared when none occurred.
// - Bit 1 is set by a zero result and cleared by a non-zero one.
// - Bit 0 is the carry out of the result's top bit, not-borrow for subtraction.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`include "csf_defines.svh"
module csf_status_flags #(
    parameter int WIDTH = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              hsel,
    input  wire logic [11:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic              repeat_loop_active,
    input  wire logic              core_flag_we,
    input  wire logic [3:0]        core_flag_mask,
    input  wire csf_pkg::csf_op_t  core_op,
    input  wire logic [WIDTH-1:0]  core_op_a,
    input  wire logic [WIDTH-1:0]  core_op_b,
    input  wire logic              core_level_we,
    input  wire logic [2:0]        core_level,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [7:0]             status_out,
    output logic [3:0]             cpu_priority_level,
    output logic                   user_irq_block
);
    import csf_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [2:0]       level_ff, nxt_level;
    logic             rpt_ff;
    logic             neg_ff, ovf_ff, zero_ff, carry_ff;
    logic             nxt_neg, nxt_ovf, nxt_zero, nxt_carry;
    logic             msb_pl_ff, nstd_ff;
    logic [1:0]       sw_op_ff;
    logic [WIDTH-1:0] sw_res_ff;
    logic             dp_wr_ff;
    logic [11:0]      dp_addr_ff;
    logic [31:0]      hrdata_ff;
    logic [7:0]       status_ff;
    logic [3:0]       pl_ff;
    logic             block_ff;
    logic [WIDTH-1:0] alu_res;
    logic             f_neg, f_ovf, f_nz, f_carry;

    // Byte view of the status register, reused for reads and the output.
    function automatic logic [7:0] pack_status(input logic [2:0] lv, input logic r,
                                               input logic n, input logic o,
                                               input logic z, input logic c);
        pack_status = {lv, r, n, o, z, c};
    endfunction

    // -----------------------------------------------------------------
    // Flag generator
    // -----------------------------------------------------------------
    csf_alu_flags #(.WIDTH(WIDTH)) u_flags (
        .op_a    (core_op_a),
        .op_b    (core_op_b),
        .op_kind (core_op),
        .result  (alu_res),
        .neg     (f_neg),
        .ovf     (f_ovf),
        .nonzero (f_nz),
        .carry   (f_carry)
    );

    // -----------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------
    wire addr_ok   = hsel && hready && htrans[1];
    wire wr_stat   = dp_wr_ff && (dp_addr_ff == `CSF_OFS_STATUS);
    wire wr_ctrl   = dp_wr_ff && (dp_addr_ff == `CSF_OFS_CTRL);
    wire wr_alu_op = dp_wr_ff && (dp_addr_ff == `CSF_OFS_ALU_OP);
    wire [7:0] cur_status = pack_status(level_ff, rpt_ff, neg_ff, ovf_ff, zero_ff, carry_ff);

    // Read mux chosen at the address phase so hrdata is a register.
    wire [31:0] rd_mux =
        (haddr == `CSF_OFS_STATUS)  ? {24'h000000, cur_status} :
        (haddr == `CSF_OFS_CTRL)    ? {30'h00000000, nstd_ff, msb_pl_ff} :
        (haddr == `CSF_OFS_ALU_OP)  ? {30'h00000000, sw_op_ff} :
        (haddr == `CSF_OFS_ALU_RES) ? {{(32-WIDTH){1'b0}}, sw_res_ff} : 32'h00000000;

    // Software writes to the status byte drive the flags through the same path.
    wire       sw_flag = wr_stat;
    wire [3:0] upd     = sw_flag ? 4'hf : (core_flag_we ? core_flag_mask : 4'h0);

    // Next flag values: a software write sets all four, else the core update sets its masked bits, others hold.
    always_comb begin
        nxt_neg   = neg_ff;
        nxt_ovf   = ovf_ff;
        nxt_zero  = zero_ff;
        nxt_carry = carry_ff;
        if (sw_flag) begin
            {nxt_neg, nxt_ovf, nxt_zero, nxt_carry} = hwdata[3:0];
        end else begin
            if (upd[3]) nxt_neg = f_neg;
            if (upd[2]) nxt_ovf = f_ovf;
            if (upd[1]) nxt_zero = ~f_nz;
            if (upd[0]) nxt_carry = f_carry;
        end
    end

    // Level: the core has priority; software is locked out under nesting disable.
    always_comb begin
        nxt_level = level_ff;
        if (core_level_we) begin
            nxt_level = core_level;
        end else if (wr_stat && !nstd_ff) begin
            nxt_level = hwdata[`CSF_BIT_LVL_HI:`CSF_BIT_LVL_LO];
        end
    end

    // Bus phase capture.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dp_wr_ff   <= 1'b0;
            dp_addr_ff <= 12'h000;
            hrdata_ff  <= 32'h00000000;
        end else begin
            dp_wr_ff   <= addr_ok && hwrite;
            dp_addr_ff <= haddr;
            if (addr_ok && !hwrite) hrdata_ff <= rd_mux;
        end
    end

    // Flags and level registers; unselected flags keep their value.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_ff <= `CSF_RST_LEVEL;
            rpt_ff   <= 1'b0;
            {neg_ff, ovf_ff, zero_ff, carry_ff} <= 4'h0;
        end else begin
            level_ff <= nxt_level;
            rpt_ff   <= repeat_loop_active;
            {neg_ff, ovf_ff, zero_ff, carry_ff} <= {nxt_neg, nxt_ovf, nxt_zero, nxt_carry};
        end
    end

    // Control and software ALU registers.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msb_pl_ff <= 1'b0;
            nstd_ff   <= 1'b0;
            sw_op_ff  <= 2'h3;
            sw_res_ff <= '0;
        end else begin
            if (wr_ctrl) {nstd_ff, msb_pl_ff} <= hwdata[1:0];
            if (wr_alu_op) sw_op_ff <= hwdata[1:0];
            if (core_flag_we) sw_res_ff <= alu_res;
        end
    end

    // Output registers follow the next state so they match the flags.
    wire [7:0] nxt_status = pack_status(nxt_level, repeat_loop_active, nxt_neg, nxt_ovf,
                                        nxt_zero, nxt_carry);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_ff <= `CSF_RST_STATUS;
            pl_ff     <= 4'h0;
            block_ff  <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            pl_ff     <= {wr_ctrl ? hwdata[0] : msb_pl_ff, nxt_level};
            block_ff  <= (nxt_level == `CSF_LEVEL_MAX) || (wr_ctrl ? hwdata[0] : msb_pl_ff);
        end
    end

    assign hrdata             = hrdata_ff;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign status_out         = status_ff;
    assign cpu_priority_level = pl_ff;
    assign user_irq_block     = block_ff;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_locked_write;
        nstd_ff && wr_stat && !core_level_we;
    endsequence

    a_level_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_locked_write |=> $stable(level_ff))
        else $error("Level changed by software while nesting disabled.");
    a_level_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (level_ff == 3'h7) |-> user_irq_block)
        else $error("Level seven did not block user interrupts.");
    a_msb_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
        user_irq_block |-> (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
        else $error("Interrupt block without cause.");
    a_repeat_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        repeat_loop_active |=> status_out[4])
        else $error("Repeat bit not set during loop.");
    a_neg_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_flag_we && core_flag_mask[3] && !sw_flag) |=> (neg_ff == $past(f_neg)))
        else $error("Negative flag wrong.");
    a_ovf_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_flag_we && core_flag_mask[2] && !sw_flag) |=> (ovf_ff == $past(f_ovf)))
        else $error("Overflow flag wrong.");
    a_zero_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_flag_we && core_flag_mask[1] && !sw_flag) |=> (zero_ff == !$past(f_nz)))
        else $error("Zero flag wrong.");
    a_carry_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_flag_we && core_flag_mask[0] && !sw_flag) |=> (carry_ff == $past(f_carry)))
        else $error("Carry flag wrong.");
    a_flag_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!core_flag_we && !sw_flag) |=> $stable({neg_ff, ovf_ff, zero_ff, carry_ff}))
        else $error("Flags changed without update.");
    a_level_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
        core_level_we |=> (status_out[7:5] == $past(core_level)))
        else $error("Level field does not follow core.");
endmodule
